//--- src/rie_irq_enable.sv
/*
 * Upper radio interrupt-enable block: enable set/clear over APB, sticky
 * event status with write-one-to-clear, one level interrupt output.
 * Assumes APB master on pclk, event pulses synchronous to pclk.
 */
// Contract
// - Write 1 to energy_detect_stopped enables that event's interrupt.
// - Write 1 to channel_clear_idle enables the channel-idle interrupt.
// - Write 1 to channel_clear_busy enables the channel-busy interrupt.
// - Write 1 to channel_clear_stopped enables the assessment-stopped interrupt.
// - Write 1 to rate_boost_switch enables the rate-boost interrupt.
// - Write 1 to transmit_ready enables the ready-to-transmit interrupt.
// - Write 1 to receive_ready enables the ready-to-receive interrupt.
// - Write 1 to mac_header_match enables the header-match interrupt.
// - Write 1 to preamble_sync_detect enables the preamble sync interrupt.
// - Preamble sync reported during reception in the three long-range/PAN modes only.
// - Write 1 to phy_frame_end enables the frame-end interrupt.
// - Write 1 to tone_extension_present enables the tone-extension interrupt.
`timescale 1ns/1ps

module rie_irq_enable (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rie_pkg::rie_events_t events,
    input wire logic rx_active,
    input wire rie_pkg::rie_mode_t rx_mode,
    output logic irq,
    output logic [31:0] enable_state
);

    rie_pkg::rie_apb_req_t req;
    logic [31:0] status;
    logic [31:0] event_vec;
    logic [31:0] next_rdata;
    logic next_err;
    logic access;
    logic commit;
    logic sync_allowed;

    // Address decode for the error path; the read path decodes separately
    function automatic logic rie_mapped(input logic [11:0] a);
        if (a == rie_pkg::OFS_EVENT_STATUS) begin
            return 1'b1;
        end else if (a == rie_pkg::OFS_ENABLE_SET) begin
            return 1'b1;
        end else if (a == rie_pkg::OFS_ENABLE_CLEAR) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : rie_mapped

    assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    assign access = psel && penable && !pready;
    // Write lands at the edge where the master sees pready high
    assign commit = psel && penable && pready && req.pwrite;

    // Sync may misfire; only the mode and receive window are checked
    assign sync_allowed = rx_active && (rx_mode != rie_pkg::RIE_MODE_OTHER);

    // Map event pulses onto their field positions
    always_comb begin
        event_vec = rie_pkg::READ_ZERO;
        event_vec[rie_pkg::POS_ENERGY_DETECT_STOPPED] = events.energy_detect_stopped;
        event_vec[rie_pkg::POS_CHANNEL_CLEAR_IDLE] = events.channel_clear_idle;
        event_vec[rie_pkg::POS_CHANNEL_CLEAR_BUSY] = events.channel_clear_busy;
        event_vec[rie_pkg::POS_CHANNEL_CLEAR_STOPPED] = events.channel_clear_stopped;
        event_vec[rie_pkg::POS_RATE_BOOST_SWITCH] = events.rate_boost_switch;
        event_vec[rie_pkg::POS_TRANSMIT_READY] = events.transmit_ready;
        event_vec[rie_pkg::POS_RECEIVE_READY] = events.receive_ready;
        event_vec[rie_pkg::POS_MAC_HEADER_MATCH] = events.mac_header_match;
        event_vec[rie_pkg::POS_PREAMBLE_SYNC_DETECT] =
            events.preamble_sync_detect && sync_allowed;
        event_vec[rie_pkg::POS_PHY_FRAME_END] = events.phy_frame_end;
        event_vec[rie_pkg::POS_TONE_EXTENSION_PRESENT] = events.tone_extension_present;
    end

    // Enable and status fields, one flop each; set wins over clear
    generate
        for (genvar i = 0; i < rie_pkg::NUM_EVENTS; i++) begin : g_field
            localparam int P = rie_pkg::FIELD_POS[i];
            logic set_hit;
            logic clr_hit;
            logic st_clr;
            assign set_hit = commit && (req.paddr == rie_pkg::OFS_ENABLE_SET)
                && req.pwdata[P];
            assign clr_hit = commit && (req.paddr == rie_pkg::OFS_ENABLE_CLEAR)
                && req.pwdata[P];
            assign st_clr = commit && (req.paddr == rie_pkg::OFS_EVENT_STATUS)
                && req.pwdata[P];

            // Zero bits in a set write change nothing
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    enable_state[P] <= rie_pkg::RESET_ENABLE[P];
                end else if (set_hit) begin
                    enable_state[P] <= 1'b1;
                end else if (clr_hit) begin
                    enable_state[P] <= 1'b0;
                end
            end

            // Sticky event flag; a new event beats a same-cycle clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status[P] <= rie_pkg::RESET_STATUS[P];
                end else if (event_vec[P]) begin
                    status[P] <= 1'b1;
                end else if (st_clr) begin
                    status[P] <= 1'b0;
                end
            end
        end
    endgenerate

    // Unused bit positions hold zero
    generate
        for (genvar b = 0; b < 32; b++) begin : g_zero
            if (!rie_pkg::FIELD_MASK[b]) begin : g_tie
                assign enable_state[b] = 1'b0;
                assign status[b] = 1'b0;
            end
        end
    endgenerate

    // Read data and error, prepared for the access phase
    always_comb begin
        next_err = !rie_mapped(req.paddr);
        if (req.pwrite) begin
            next_rdata = rie_pkg::READ_ZERO;
        end else if (req.paddr == rie_pkg::OFS_EVENT_STATUS) begin
            next_rdata = status & rie_pkg::FIELD_MASK;
        end else if (req.paddr == rie_pkg::OFS_ENABLE_SET) begin
            next_rdata = enable_state & rie_pkg::FIELD_MASK;
        end else if (req.paddr == rie_pkg::OFS_ENABLE_CLEAR) begin
            next_rdata = enable_state & rie_pkg::FIELD_MASK;
        end else begin
            next_rdata = rie_pkg::READ_ZERO;
        end
    end

    // One wait state: pready rises one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= rie_pkg::READ_ZERO;
        end else if (access) begin
            pready <= 1'b1;
            pslverr <= next_err;
            prdata <= next_rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= rie_pkg::READ_ZERO;
        end
    end

    // Level interrupt, registered to keep the output glitch-free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & enable_state & rie_pkg::FIELD_MASK);
        end
    end

endmodule : rie_irq_enable

//--- src/rie_pkg.sv
/*
 * Constants and types for the upper radio interrupt-enable block:
 * register offsets, field positions, reset values and the bus carrier.
 * Assumes a 32-bit APB register bus and one system clock.
 */
package rie_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h100;
    localparam logic [11:0] OFS_ENABLE_SET = 12'h304;
    localparam logic [11:0] OFS_ENABLE_CLEAR = 12'h308;

    localparam logic [31:0] RESET_ENABLE = 32'h00000000;
    localparam logic [31:0] RESET_STATUS = 32'h00000000;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // Number of event fields in the upper part
    localparam int NUM_EVENTS = 11;

    // Field positions, index order matches rie_events_t from LSB upward
    localparam int FIELD_POS [NUM_EVENTS] = '{16, 17, 18, 19, 20, 21, 22, 23, 26, 27, 28};

    localparam int POS_ENERGY_DETECT_STOPPED = 16;
    localparam int POS_CHANNEL_CLEAR_IDLE = 17;
    localparam int POS_CHANNEL_CLEAR_BUSY = 18;
    localparam int POS_CHANNEL_CLEAR_STOPPED = 19;
    localparam int POS_RATE_BOOST_SWITCH = 20;
    localparam int POS_TRANSMIT_READY = 21;
    localparam int POS_RECEIVE_READY = 22;
    localparam int POS_MAC_HEADER_MATCH = 23;
    localparam int POS_PREAMBLE_SYNC_DETECT = 26;
    localparam int POS_PHY_FRAME_END = 27;
    localparam int POS_TONE_EXTENSION_PRESENT = 28;

    // Bits that exist; all others read as zero
    localparam logic [31:0] FIELD_MASK = 32'h1CFF0000;

    // Receive modes; preamble sync may be reported in all but RIE_MODE_OTHER
    typedef enum logic [1:0] {
        RIE_MODE_OTHER,
        RIE_MODE_LONG_RANGE_125K,
        RIE_MODE_LONG_RANGE_500K,
        RIE_MODE_LOW_RATE_PAN_250K
    } rie_mode_t;

    // One-cycle event pulses from the radio core
    typedef struct packed {
        logic tone_extension_present;
        logic phy_frame_end;
        logic preamble_sync_detect;
        logic mac_header_match;
        logic receive_ready;
        logic transmit_ready;
        logic rate_boost_switch;
        logic channel_clear_stopped;
        logic channel_clear_busy;
        logic channel_clear_idle;
        logic energy_detect_stopped;
    } rie_events_t;

    // APB request as held through a transfer
    typedef struct packed {
        logic [11:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } rie_apb_req_t;

endpackage : rie_pkg

//--- bench/rie_chk.sv
/* Port checker for the upper radio interrupt-enable block.
   Assumes it is bound to the top module's ports, one clock domain. */
`timescale 1ns/1ps
module rie_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [31:0] enable_state
);
    logic done;
    logic wr_set;
    logic wr_clr;
    // Completed transfer decode, unmapped ones excluded
    assign done = psel && penable && pready && !pslverr;
    assign wr_set = done && pwrite && paddr == rie_pkg::OFS_ENABLE_SET;
    assign wr_clr = done && pwrite && paddr == rie_pkg::OFS_ENABLE_CLEAR;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_SET: assert property (wr_set |=> (enable_state & rie_pkg::FIELD_MASK) ==
        (($past(enable_state) | $past(pwdata)) & rie_pkg::FIELD_MASK)) else $error("set lost");
    AST_HOLD: assert property (!(done && pwrite) |=> $stable(enable_state))
        else $error("enable moved");
    AST_CLR: assert property (wr_clr |=> (enable_state & $past(pwdata) &
        rie_pkg::FIELD_MASK) == 32'h00000000) else $error("clear lost");
    AST_READ: assert property (done && !pwrite && paddr == rie_pkg::OFS_ENABLE_SET
        |-> prdata == enable_state) else $error("readback wrong");
    AST_IRQ: assert property (irq |-> $past(enable_state) != 32'h00000000)
        else $error("irq without enable");
    AST_WAIT: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("wait state wrong");
    AST_ONE: assert property (pready |=> !pready) else $error("pready stuck");
    AST_RDZ: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
        else $error("idle outputs");
    cover property (wr_set);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule : rie_chk

//--- bench/testbench.sv
/* Self-checking bench for the upper radio interrupt-enable block.
   Assumes the package and the design are compiled first. */
`timescale 1ns/1ps
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_active = 1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, enable_state, rd, exp_en, bit_i;
    logic pready, pslverr, irq, err;
    rie_pkg::rie_events_t events = '0;
    rie_pkg::rie_mode_t rx_mode = rie_pkg::RIE_MODE_LONG_RANGE_125K;
    int fails = 0, n_compared = 0;
    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;
    rie_irq_enable DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .events(events), .rx_active(rx_active), .rx_mode(rx_mode),
        .irq(irq), .enable_state(enable_state));
    task give_verdict;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // One APB transfer; holds the request until pready is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // A late answer on the last try still counts as an answer
        if (pready !== 1'h1) begin
            fails++;
            give_verdict();
        end
    endtask : apb
    // One-cycle event pulse, then let status and irq settle
    task pulse(input int i);
        @(posedge pclk) events <= rie_pkg::rie_events_t'(11'h001 << i);
        @(posedge pclk) events <= '0;
        repeat (3) @(posedge pclk);
    endtask : pulse
    initial begin
        exp_en = 32'h00000000;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, rie_pkg::OFS_ENABLE_SET, 32'h00000000);
        chk("reset enable", 32'h00000000, rd);
        chk("reset irq", 32'h00000000, {31'h0, irq});
        for (int i = 0; i < rie_pkg::NUM_EVENTS; i++) begin
            bit_i = 32'h00000001 << rie_pkg::FIELD_POS[i];
            // Event latches in status even while its enable is off
            pulse(i);
            chk("irq masked", 32'h00000000, {31'h0, irq});
            apb(1'h0, rie_pkg::OFS_EVENT_STATUS, 32'h00000000);
            chk("status", bit_i, rd);
            exp_en = exp_en | bit_i;
            apb(1'h1, rie_pkg::OFS_ENABLE_SET, bit_i);
            repeat (2) @(posedge pclk);
            chk("irq enabled", 32'h00000001, {31'h0, irq});
            apb(1'h1, rie_pkg::OFS_ENABLE_SET, 32'h00000000);
            apb(1'h0, rie_pkg::OFS_ENABLE_SET, 32'h00000000);
            chk("enable read", exp_en, rd);
            chk("enable port", exp_en, enable_state);
            apb(1'h1, rie_pkg::OFS_EVENT_STATUS, 32'hFFFFFFFF);
            repeat (2) @(posedge pclk);
            chk("irq cleared", 32'h00000000, {31'h0, irq});
        end
        // Sync pulses outside reception or in other modes are dropped
        rx_active <= 1'h0;
        pulse(8);
        chk("sync idle", 32'h00000000, {31'h0, irq});
        rx_active <= 1'h1;
        rx_mode <= rie_pkg::RIE_MODE_OTHER;
        pulse(8);
        chk("sync mode", 32'h00000000, {31'h0, irq});
        apb(1'h0, rie_pkg::OFS_EVENT_STATUS, 32'h00000000);
        chk("sync dropped", 32'h00000000, rd);
        for (int m = 1; m < 4; m++) begin
            rx_mode <= rie_pkg::rie_mode_t'(m);
            pulse(8);
            chk("sync rx", 32'h00000001, {31'h0, irq});
            apb(1'h1, rie_pkg::OFS_EVENT_STATUS, 32'hFFFFFFFF);
        end
        apb(1'h1, rie_pkg::OFS_ENABLE_CLEAR, rie_pkg::FIELD_MASK);
        apb(1'h0, rie_pkg::OFS_ENABLE_CLEAR, 32'h00000000);
        chk("cleared", 32'h00000000, rd);
        chk("cleared port", 32'h00000000, enable_state);
        // Unmapped address: error response, a write there changes nothing
        apb(1'h1, 12'h0FC, rie_pkg::FIELD_MASK);
        chk("unmapped wr err", 32'h00000001, {31'h0, err});
        chk("unmapped no set", 32'h00000000, enable_state);
        apb(1'h0, 12'h0FC, 32'h00000000);
        chk("unmapped err", 32'h00000001, {31'h0, err});
        chk("unmapped rd", 32'h00000000, rd);
        // Reset in mid-run with enables and a pending event set
        apb(1'h1, rie_pkg::OFS_ENABLE_SET, rie_pkg::FIELD_MASK);
        pulse(0);
        chk("irq before reset", 32'h00000001, {31'h0, irq});
        chk("enable before reset", rie_pkg::FIELD_MASK, enable_state);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        chk("rerun irq", 32'h00000000, {31'h0, irq});
        chk("rerun port", 32'h00000000, enable_state);
        apb(1'h0, rie_pkg::OFS_ENABLE_SET, 32'h00000000);
        chk("rerun reset", 32'h00000000, rd);
        apb(1'h0, rie_pkg::OFS_EVENT_STATUS, 32'h00000000);
        chk("rerun status", 32'h00000000, rd);
        give_verdict();
    end
endmodule : testbench
bind rie_irq_enable rie_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .enable_state(enable_state));
